//--- logic/nvs_mem_slave.sv
// nvs_mem_slave: two-wire serial slave in front of a nonvolatile byte array
// assumes: SCL, SDA, select and protect pins are asynchronous to CORE_CLK;
// WR_READY comes from logic on CORE_CLK; SDA wire is resolved outside
//
// How it works
// - write: address with direction 0, two address bytes, then data; each kept byte acked
// - sequential write wraps address counter from top location to zero
// - no busy period; a data byte arriving while the two-entry write buffer is full is nacked
// - byte committed at eighth bit before ack; no page buffer; earlier start/stop aborts
// - protect high: data bytes nacked, not written, address counter held
// - protect low means unprotected; an open pin reads low
// - address with direction 1 starts shifting current-address byte next clock
// - read increments counter after every byte; master ack brings next byte
// - read address wraps from top location to zero
// - selective read: write the address, repeated start, then a current read
// - sleep: reserved id one, target address, restart, sleep code acked, stop sleeps
// - after reserved id one only the matching slave acks the address byte
// - asleep the slave watches the bus and wakes on its own address
// - until wake completes every access is nacked
// - id read: reserved id one, target, restart, reserved id two, three id bytes
// - id stream: twelve manufacturer bits, nine part bits, three revision bits
// - master nack on an id byte ends the read and resets the protocol
// - slave address: type in bits 7-4, select pins in 3-1, direction bit 0
// - memory address two bytes, high first; fifteen bits kept as current address
// - high-speed master code enters high-speed mode; stop leaves it
`include "nvs_defines.svh"

module nvs_mem_slave
  import nvs_pkg::*;
#(
  parameter int          ADDR_W      = `NVS_ADDR_W,
  parameter int          WAKE_CYCLES = `NVS_WAKE_CYCLES,
  parameter logic [11:0] MFR_ID      = `NVS_MFR_ID,
  parameter logic [8:0]  PART_ID     = `NVS_PART_ID,
  parameter logic [2:0]  DIE_REV     = `NVS_DIE_REV
) (
  input  wire  logic              CORE_CLK,
  input  wire  logic              RST,
  input  wire  logic              SCL,
  input  wire  logic              SDA_IN,
  output logic                    SDA_OUT,
  output logic                    SDA_OE,
  input  wire  logic [2:0]        DEVICE_SELECT_PINS,
  input  wire  logic              WRITE_PROTECT,
  output logic                    WR_VALID,
  output logic [ADDR_W-1:0]       WR_ADDR,
  output logic [7:0]              WR_DATA,
  input  wire  logic              WR_READY,
  output logic                    SLEEP,
  output logic                    WAKING,
  output logic                    HS_MODE,
  output logic [ADDR_W-1:0]       CUR_ADDR
);

  localparam int DEPTH  = 1 << ADDR_W;
  localparam int WAKE_W = $clog2(WAKE_CYCLES + 1);

  // --------------------------------------------------------------------------
  // pin synchronisers and bus conditions
  // --------------------------------------------------------------------------
  logic [1:0]        scl_sync;
  logic [1:0]        sda_sync;
  logic [1:0]        wp_sync;
  logic [2:0]        sel_meta;
  logic [2:0]        sel_sync;
  logic              scl_d;
  logic              sda_d;
  logic              scl_s;
  logic              sda_s;
  logic              scl_rise;
  logic              scl_fall;
  logic              start_cond;
  logic              stop_cond;

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
      wp_sync  <= 2'h0;
      sel_meta <= 3'h0;
      sel_sync <= 3'h0;
      scl_d    <= 1'b1;
      sda_d    <= 1'b1;
    end else begin
      scl_sync <= {scl_sync[0], SCL};
      sda_sync <= {sda_sync[0], SDA_IN};
      wp_sync  <= {wp_sync[0], WRITE_PROTECT};
      sel_meta <= DEVICE_SELECT_PINS;
      sel_sync <= sel_meta;
      scl_d    <= scl_sync[1];
      sda_d    <= sda_sync[1];
    end
  end

  assign scl_s      = scl_sync[1];
  assign sda_s      = sda_sync[1];
  assign scl_rise   = scl_s & ~scl_d;
  assign scl_fall   = ~scl_s & scl_d;
  assign start_cond = scl_s & scl_d & sda_d & ~sda_s;
  assign stop_cond  = scl_s & scl_d & ~sda_d & sda_s;

  // --------------------------------------------------------------------------
  // bit counter and receive shifter
  // --------------------------------------------------------------------------
  nvs_state_t        state;
  nvs_state_t        after;
  nvs_state_t        next_after;
  logic [3:0]        cnt;
  logic [7:0]        rx;
  logic [7:0]        rx_byte;
  logic              rx_state;
  logic              tx_state;
  logic              byte_done;
  logic              ack_rise;
  logic              mack;

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      cnt <= 4'h0;
      rx  <= 8'h00;
    end else if (start_cond || stop_cond) begin
      cnt <= 4'h0;
    end else if (scl_rise) begin
      cnt <= (cnt == `NVS_ACK_SLOT) ? 4'h0 : cnt + 4'h1;
      if (cnt != `NVS_ACK_SLOT)
        rx <= rx_byte;
    end
  end

  assign rx_byte   = {rx[6:0], sda_s};
  assign rx_state  = (state == NVS_ADDR) || (state == NVS_RSVD_TGT) || (state == NVS_MADDR_HI) ||
                     (state == NVS_MADDR_LO) || (state == NVS_WDATA);
  assign tx_state  = (state == NVS_RDATA) || (state == NVS_ID);
  assign byte_done = scl_rise && (cnt == `NVS_LAST_BIT) && rx_state;
  assign ack_rise  = scl_rise && (cnt == `NVS_ACK_SLOT);
  assign mack      = ~sda_s;

  // --------------------------------------------------------------------------
  // byte decode
  // --------------------------------------------------------------------------
  logic              asleep;
  logic              waking;
  logic              rsvd_armed;
  logic              ack_ok;
  logic              next_ack;
  logic              is_match;
  logic              busy;
  logic              commit_ok;
  logic              commit;
  logic              buf_in_ready;

  assign is_match  = (rx_byte[7:4] == `NVS_DEV_TYPE) && (rx_byte[3:1] == sel_sync);
  assign busy      = asleep | waking;
  assign commit_ok = ~wp_sync[1] & buf_in_ready;
  assign commit    = byte_done && (state == NVS_WDATA) && commit_ok;

  always_comb begin
    next_ack   = 1'b0;
    next_after = NVS_WAIT;
    case (state)
      NVS_ADDR: begin
        if (busy) begin
          next_ack = 1'b0;
        end else if (rsvd_armed && rx_byte == `NVS_SLEEP_CODE) begin
          next_ack = 1'b1;
        end else if (rsvd_armed && rx_byte == `NVS_RSVD_ID2) begin
          next_ack   = 1'b1;
          next_after = NVS_ID;
        end else if (rx_byte == `NVS_RSVD_ID1) begin
          next_ack   = 1'b1;
          next_after = NVS_RSVD_TGT;
        end else if (is_match) begin
          next_ack   = 1'b1;
          next_after = rx_byte[0] ? NVS_RDATA : NVS_MADDR_HI;
        end
      end
      NVS_RSVD_TGT: next_ack = is_match & ~busy;
      NVS_MADDR_HI: begin
        next_ack   = 1'b1;
        next_after = NVS_MADDR_LO;
      end
      NVS_MADDR_LO: begin
        next_ack   = 1'b1;
        next_after = NVS_WDATA;
      end
      NVS_WDATA: begin
        next_ack   = commit_ok;
        next_after = commit_ok ? NVS_WDATA : NVS_WAIT;
      end
      default: begin
        next_ack   = 1'b0;
        next_after = NVS_WAIT;
      end
    endcase
  end

  // --------------------------------------------------------------------------
  // protocol sequencing
  // --------------------------------------------------------------------------
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      state      <= NVS_IDLE;
      after      <= NVS_WAIT;
      ack_ok     <= 1'b0;
      rsvd_armed <= 1'b0;
    end else if (stop_cond) begin
      state      <= NVS_IDLE;
      rsvd_armed <= 1'b0;
    end else if (start_cond) begin
      state <= NVS_ADDR;
    end else if (byte_done) begin
      after  <= next_after;
      ack_ok <= next_ack;
      if (state == NVS_ADDR)
        rsvd_armed <= 1'b0;
      else if (state == NVS_RSVD_TGT)
        rsvd_armed <= is_match & ~busy;
    end else if (ack_rise) begin
      if (tx_state)
        state <= mack ? state : NVS_IDLE;
      else if (rx_state)
        state <= after;
    end
  end

  // --------------------------------------------------------------------------
  // current address latch
  // --------------------------------------------------------------------------
  logic [ADDR_W-1:0] cur_addr;
  logic [ADDR_W-9:0] addr_hi;

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      cur_addr <= '0;
      addr_hi  <= '0;
    end else if (byte_done && state == NVS_MADDR_HI) begin
      addr_hi <= rx_byte[ADDR_W-9:0];
    end else if (byte_done && state == NVS_MADDR_LO) begin
      cur_addr <= {addr_hi, rx_byte};
    end else if (commit) begin
      cur_addr <= cur_addr + 1'b1;
    end else if (scl_rise && cnt == `NVS_LAST_BIT && state == NVS_RDATA) begin
      cur_addr <= cur_addr + 1'b1;
    end
  end

  // --------------------------------------------------------------------------
  // array
  // --------------------------------------------------------------------------
  logic [7:0]        mem [DEPTH];

  always_ff @(posedge CORE_CLK) begin
    if (commit)
      mem[cur_addr] <= rx_byte;
  end

  // --------------------------------------------------------------------------
  // transmit byte
  // --------------------------------------------------------------------------
  logic [7:0]        tx;
  logic [1:0]        id_idx;
  logic [7:0]        id_byte;
  logic [23:0]       id_word;

  assign id_word = {MFR_ID, PART_ID, DIE_REV};

  always_comb begin
    case (id_idx)
      2'h0:    id_byte = id_word[23:16];
      2'h1:    id_byte = id_word[15:8];
      default: id_byte = id_word[7:0];
    endcase
  end

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      tx     <= 8'h00;
      id_idx <= 2'h0;
    end else if (ack_rise) begin
      if (rx_state && after == NVS_RDATA) begin
        tx <= mem[cur_addr];
      end else if (rx_state && after == NVS_ID) begin
        tx     <= id_word[23:16];
        id_idx <= 2'h1;
      end else if (state == NVS_RDATA && mack) begin
        tx <= mem[cur_addr];
      end else if (state == NVS_ID && mack) begin
        tx     <= id_byte;
        id_idx <= (id_idx == 2'h2) ? 2'h0 : id_idx + 2'h1;
      end
    end
  end

  // --------------------------------------------------------------------------
  // data line drive, set while the clock is low; a start or stop condition releases it
  // --------------------------------------------------------------------------
  logic              drive;

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      drive <= 1'b0;
    end else if (start_cond || stop_cond) begin
      drive <= 1'b0;
    end else if (scl_fall) begin
      if (cnt == `NVS_ACK_SLOT)
        drive <= rx_state & ack_ok;
      else if (tx_state)
        drive <= ~tx[3'(`NVS_LAST_BIT - cnt)];
      else
        drive <= 1'b0;
    end
  end

  assign SDA_OUT = 1'b0;
  assign SDA_OE  = drive;

  // --------------------------------------------------------------------------
  // sleep and wake
  // --------------------------------------------------------------------------
  logic              sleep_arm;
  logic [WAKE_W-1:0] wake_cnt;

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      sleep_arm <= 1'b0;
      asleep    <= 1'b0;
      waking    <= 1'b0;
      wake_cnt  <= '0;
    end else begin
      if (stop_cond) begin
        sleep_arm <= 1'b0;
        if (sleep_arm)
          asleep <= 1'b1;
      end else if (start_cond && sleep_arm) begin
        sleep_arm <= 1'b0;
      end else if (byte_done && state == NVS_ADDR && !busy && rsvd_armed && rx_byte == `NVS_SLEEP_CODE) begin
        sleep_arm <= 1'b1;
      end
      if (byte_done && state == NVS_ADDR && asleep && is_match) begin
        asleep   <= 1'b0;
        waking   <= 1'b1;
        wake_cnt <= WAKE_W'(WAKE_CYCLES - 1);
      end else if (waking) begin
        if (wake_cnt == '0)
          waking <= 1'b0;
        else
          wake_cnt <= wake_cnt - 1'b1;
      end
    end
  end

  // --------------------------------------------------------------------------
  // high-speed mode flag
  // --------------------------------------------------------------------------
  logic              hs_mode;

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST)
      hs_mode <= 1'b0;
    else if (stop_cond)
      hs_mode <= 1'b0;
    else if (byte_done && state == NVS_ADDR && rx_byte[7:3] == `NVS_HS_CODE)
      hs_mode <= 1'b1;
  end

  // --------------------------------------------------------------------------
  // two-entry buffer of committed writes
  // --------------------------------------------------------------------------
  logic [ADDR_W-1:0] buf_addr [`NVS_BUF_DEPTH];
  logic [7:0]        buf_data [`NVS_BUF_DEPTH];
  logic              wr_ptr;
  logic              rd_ptr;
  logic [1:0]        buf_cnt;
  logic              pop;

  assign buf_in_ready = (buf_cnt != 2'h2);
  assign pop          = WR_VALID & WR_READY;

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      wr_ptr  <= 1'b0;
      rd_ptr  <= 1'b0;
      buf_cnt <= 2'h0;
    end else begin
      if (commit)
        wr_ptr <= ~wr_ptr;
      if (pop)
        rd_ptr <= ~rd_ptr;
      if (commit && !pop)
        buf_cnt <= buf_cnt + 2'h1;
      else if (pop && !commit)
        buf_cnt <= buf_cnt - 2'h1;
    end
  end

  for (genvar i = 0; i < `NVS_BUF_DEPTH; i++) begin : g_buf
    always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
        buf_addr[i] <= '0;
        buf_data[i] <= 8'h00;
      end else if (commit && wr_ptr == 1'(i)) begin
        buf_addr[i] <= cur_addr;
        buf_data[i] <= rx_byte;
      end
    end
  end

  assign WR_VALID = (buf_cnt != 2'h0);
  assign WR_ADDR  = buf_addr[rd_ptr];
  assign WR_DATA  = buf_data[rd_ptr];
  assign SLEEP    = asleep;
  assign WAKING   = waking;
  assign HS_MODE  = hs_mode;
  assign CUR_ADDR = cur_addr;

endmodule

//--- logic/nvs_defines.svh
// nvs_defines.svh: offsets, codes and timing counts of the serial memory slave
// assumes: included by bare name wherever the constants are needed
`ifndef NVS_DEFINES_SVH
`define NVS_DEFINES_SVH

// --------------------------------------------------------------------------
// bus codes
// --------------------------------------------------------------------------
`define NVS_ADDR_W           15
`define NVS_DEV_TYPE         4'ha
`define NVS_RSVD_ID1         8'hf8
`define NVS_RSVD_ID2         8'hf9
`define NVS_SLEEP_CODE       8'h86
`define NVS_HS_CODE          5'h01
`define NVS_LAST_BIT         4'h7
`define NVS_ACK_SLOT         4'h8
`define NVS_BUF_DEPTH        2

// --------------------------------------------------------------------------
// identification fields (arbitrary neutral values)
// --------------------------------------------------------------------------
`define NVS_MFR_ID           12'h05a
`define NVS_PART_ID          9'h0c3
`define NVS_DIE_REV          3'h1

// --------------------------------------------------------------------------
// timing
// --------------------------------------------------------------------------
`define NVS_CLK_PERIOD_NS    100
`define NVS_WAKE_RECOVERY_NS 400000
`define NVS_WAKE_CYCLES      (`NVS_WAKE_RECOVERY_NS / `NVS_CLK_PERIOD_NS)

`endif

//--- logic/nvs_pkg.sv
// nvs_pkg: types of the serial memory slave
// assumes: compiled before the slave module
package nvs_pkg;

  typedef enum logic [3:0] {
    NVS_IDLE,
    NVS_ADDR,
    NVS_RSVD_TGT,
    NVS_MADDR_HI,
    NVS_MADDR_LO,
    NVS_WDATA,
    NVS_RDATA,
    NVS_ID,
    NVS_WAIT
  } nvs_state_t;

endpackage

//--- testbench/nvs_mem_slave_sva.sv
// nvs_mem_slave_sva: port checks for the serial memory slave
// assumes: bound into nvs_mem_slave; one clock domain, RST async high
module nvs_mem_slave_sva
  import nvs_pkg::*;
#(
  parameter int ADDR_W      = 15,
  parameter int WAKE_CYCLES = 20
) (
  input wire logic              CORE_CLK,
  input wire logic              RST,
  input wire logic              SCL,
  input wire logic              SDA_OE,
  input wire logic              WRITE_PROTECT,
  input wire logic              WR_VALID,
  input wire logic [ADDR_W-1:0] WR_ADDR,
  input wire logic [7:0]        WR_DATA,
  input wire logic              WR_READY,
  input wire logic              SLEEP,
  input wire logic              WAKING,
  input wire logic [ADDR_W-1:0] CUR_ADDR
);
  timeunit 1ns;
  timeprecision 1ns;
  int wake_cnt;

  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (RST);

  // ----------
  // wake recovery length
  // ----------
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      wake_cnt <= 0;
    end else if (WAKING) begin
      wake_cnt <= wake_cnt + 1;
    end else begin
      wake_cnt <= 0;
    end
  end

  sequence s_wake_begin;
    $fell(SLEEP) ##0 WAKING;
  endsequence

  // ----------
  // checks
  // ----------
  AST_OE_AFTER_FALL:
    assert property ($rose(SDA_OE) |-> !$past(SCL, 2)) else $error("sda drive began with scl high");
  AST_OE_STANDS:
    assert property ($rose(SDA_OE) |=> SDA_OE[*6]) else $error("sda drive cut short");
  AST_PROT_NO_PUSH:
    assert property ($rose(WR_VALID) |-> !$past(WRITE_PROTECT, 3)) else $error("write kept while protected");
  AST_CUR_STEP:
    assert property ($rose(WR_VALID) |-> CUR_ADDR == WR_ADDR + 1'b1) else $error("address not advanced");
  AST_WR_HOLD:
    assert property (WR_VALID && !WR_READY |=> WR_VALID && $stable(WR_ADDR) && $stable(WR_DATA))
      else $error("stalled write entry changed");
  AST_ASLEEP_NACK:
    assert property (SLEEP || WAKING |-> !SDA_OE) else $error("ack while asleep or waking");
  AST_SLEEP_EXCL:
    assert property (!(SLEEP && WAKING)) else $error("sleep and waking together");
  AST_WAKE_HOLD:
    assert property (s_wake_begin |=> WAKING[*8]) else $error("wake recovery ended early");
  AST_WAKE_LEN:
    assert property ($fell(WAKING) |-> wake_cnt >= WAKE_CYCLES - 1 && wake_cnt <= WAKE_CYCLES + 1)
      else $error("wake recovery length wrong");
endmodule

bind nvs_mem_slave nvs_mem_slave_sva #(.ADDR_W(ADDR_W), .WAKE_CYCLES(WAKE_CYCLES)) u_sva (
  .CORE_CLK(CORE_CLK), .RST(RST), .SCL(SCL), .SDA_OE(SDA_OE), .WRITE_PROTECT(WRITE_PROTECT),
  .WR_VALID(WR_VALID), .WR_ADDR(WR_ADDR), .WR_DATA(WR_DATA), .WR_READY(WR_READY),
  .SLEEP(SLEEP), .WAKING(WAKING), .CUR_ADDR(CUR_ADDR));

//--- testbench/nvs_bus_master.sv
// nvs_bus_master: behavioural two-wire bus master
// assumes: sda is the resolved wire with a pull-up; tasks begin off clock edges
module nvs_bus_master (
  output logic      scl,
  output logic      sda_low,
  input  wire logic sda
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int Q = 200;

  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  // ----------
  // bus conditions
  // ----------
  task automatic start();
    sda_low = 1'b0;
    #Q scl = 1'b1;
    #Q sda_low = 1'b1;
    #Q scl = 1'b0;
    #Q;
  endtask

  task automatic stop();
    sda_low = 1'b1;
    #Q scl = 1'b1;
    #Q sda_low = 1'b0;
    #(3 * Q);
  endtask

  // ----------
  // bits and bytes, msb first
  // ----------
  task automatic bit_io(input logic b, output logic s);
    sda_low = !b;
    #Q scl = 1'b1;
    #Q s = sda;
    #Q scl = 1'b0;
    #Q;
  endtask

  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(d[i], s);
    bit_io(1'b1, s);
    ack = !s;
  endtask

  task automatic rbyte(output logic [7:0] d, input logic mack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(!mack, s);
  endtask
endmodule

//--- testbench/nvs_mem_slave_tb_top.sv
// nvs_mem_slave_tb_top: directed tests of the serial memory slave
// assumes: nvs_bus_master drives the bus; this module drains the write buffer
module nvs_mem_slave_tb_top
  import nvs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [11:0] MFR  = 12'h5c3; // arbitrary
  localparam logic [8:0]  PART = 9'h1a6;  // arbitrary
  localparam logic [2:0]  REV  = 3'h5;    // arbitrary
  localparam logic [23:0] ID   = {MFR, PART, REV};
  localparam logic [7:0]  SW   = 8'hac;
  localparam logic [7:0]  SR   = 8'had;
  logic        core_clk, rst, scl, sda, m_low, wp, wr_ready, sda_out, sda_oe;
  logic        wr_valid, sleep, waking, hs_mode;
  logic [2:0]  sel;
  logic [14:0] wr_addr, cur_addr;
  logic [7:0]  wr_data;
  logic [22:0] pops[$];
  int          failures, samples_checked;

  assign sda = !(m_low || (sda_oe && !sda_out));

  nvs_mem_slave #(.WAKE_CYCLES(150), .MFR_ID(MFR), .PART_ID(PART), .DIE_REV(REV)) u_dut (
    .CORE_CLK(core_clk), .RST(rst), .SCL(scl), .SDA_IN(sda), .SDA_OUT(sda_out), .SDA_OE(sda_oe),
    .DEVICE_SELECT_PINS(sel), .WRITE_PROTECT(wp), .WR_VALID(wr_valid), .WR_ADDR(wr_addr),
    .WR_DATA(wr_data), .WR_READY(wr_ready), .SLEEP(sleep), .WAKING(waking), .HS_MODE(hs_mode),
    .CUR_ADDR(cur_addr));
  nvs_bus_master u_mst (.scl(scl), .sda_low(m_low), .sda(sda));

  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    if (wr_valid === 1'b1 && wr_ready === 1'b1) begin
      pops.push_back({wr_addr, wr_data});
    end
  end

  // ----------
  // access tasks
  // ----------
  task automatic chk(input string n, input logic [22:0] e, input logic [22:0] g);
    samples_checked++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic chkq(input logic [14:0] a, input logic [7:0] d);
    chk("write_entry", {a, d}, pops.size() != 0 ? pops.pop_front() : 23'bx);
  endtask

  task automatic txn(input int n, input logic [47:0] b, input logic [7:0] e);
    logic a;
    u_mst.start();
    for (int i = n - 1; i >= 0; i--) begin
      u_mst.wbyte(b[8*i+:8], a);
      chk("ack", e[i], a);
    end
  endtask

  task automatic rb(input logic [7:0] e, input logic mack);
    logic [7:0] d;
    u_mst.rbyte(d, mack);
    chk("read_data", e, d);
  endtask

  task automatic final_report();
    if (failures == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    #3_000_000;
    failures++;
    final_report();
  end

  // ----------
  // tests
  // ----------
  initial begin
    rst = 1'b1;
    wp = 1'b0;
    wr_ready = 1'b1;
    sel = 3'h6;
    failures = 0;
    samples_checked = 0;
    repeat (5) @(posedge core_clk);
    @(negedge core_clk);
    rst = 1'b0;
    repeat (4) @(negedge core_clk);
    txn(6, 48'hac7ffea1b2c3, 8'h3f);
    u_mst.stop();
    chkq(15'h7ffe, 8'ha1);
    chkq(15'h7fff, 8'hb2);
    chkq(15'h0000, 8'hc3);
    chk("cur_addr", 15'h0001, cur_addr);
    txn(3, 24'hac7fff, 8'h07);
    txn(1, SR, 8'h01);
    rb(8'hb2, 1'b1);
    rb(8'hc3, 1'b0);
    u_mst.stop();
    chk("cur_addr", 15'h0001, cur_addr);
    wp = 1'b1;
    txn(4, 32'hac001055, 8'h0e);
    u_mst.stop();
    wp = 1'b0;
    chk("cur_addr", 15'h0010, cur_addr);
    chk("pushes", 0, pops.size());
    wr_ready = 1'b0;
    txn(6, 48'hac0010112233, 8'h3e);
    u_mst.stop();
    wr_ready = 1'b1;
    repeat (4) @(negedge core_clk);
    chkq(15'h0010, 8'h11);
    chkq(15'h0011, 8'h22);
    chk("pushes", 0, pops.size());
    txn(3, 24'hac0010, 8'h07);
    txn(1, SR, 8'h01);
    rb(8'h11, 1'b0);
    u_mst.stop();
    txn(1, 8'ha2, 8'h00);
    u_mst.stop();
    sel = 3'h1;
    txn(1, 8'ha2, 8'h01);
    u_mst.stop();
    sel = 3'h6;
    txn(2, 16'hf8a3, 8'h02);
    u_mst.stop();
    txn(2, {8'hf8, SR}, 8'h03);
    txn(1, 8'hf9, 8'h01);
    rb(ID[23:16], 1'b1);
    rb(ID[15:8], 1'b1);
    rb(ID[7:0], 1'b0);
    u_mst.stop();
    txn(1, 8'h08, 8'h00);
    chk("hs_mode", 1'b1, hs_mode);
    u_mst.stop();
    chk("hs_mode", 1'b0, hs_mode);
    txn(2, {8'hf8, SR}, 8'h03);
    txn(1, 8'h86, 8'h01);
    u_mst.stop();
    chk("sleep", 1'b1, sleep);
    txn(1, SW, 8'h00);
    chk("waking", 1'b1, waking);
    u_mst.stop();
    txn(1, SW, 8'h00);
    chk("waking", 1'b1, waking);
    u_mst.stop();
    repeat (100) @(negedge core_clk);
    txn(1, SW, 8'h01);
    u_mst.stop();
    chk("sleep_waking", 2'b00, {sleep, waking});
    final_report();
  end
endmodule
